// File: logic/ifb_bank.sv
// ifb_bank: interrupt request flags, enables, global enable and edge
// selects, reached as special-function registers, plus the service request.
// assumes: event inputs are one-cycle pulses on clk_sys; pins are async;
// the core raises irq_ack for one cycle when it takes the offered vector.
`default_nettype none
// What this block does
// - pin one edge code: off, rise, fall, both
// - pin zero edge code in low two bits
// - unimplemented bits read zero, ignore writes
// - global enable zero blocks every interrupt
// - control zero flags: pin0 b6, current b5, voltage b4
// - control one flags: conversion b7, groups b6-b4
// - control one enables: conversion b3, groups b2-b0
// - control two flags: pin1 b6, timebases b5, b4
// - control two enables b2-b0, bit 3 unused
// - group zero: timer0 flags b5,b4, enables b1,b0
// - group one: timer1 flags b5,b4, enables b1,b0
// - group two: eeprom, low voltage flags and enables
// - hardware sets flags, software sets enables
// - serviced interrupt diverts core, then resumes
// - sources: pins, timers, protection, timebases, voltage, eeprom, conversion
// - member flag sets group flag; members need software clear
// - service clears global enable and the serviced primary flag; other flags still set
// - pin flag set on selected edge
// - disabled request sets flag, never serviced
module ifb_bank
  import ifb_pkg::*;
(
  input wire logic clk_sys, // system clock, 50 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic [ifb_pkg::SEL_W-1:0] sfr_sel, // register select
  input wire logic sfr_wr, // write strobe, one cycle
  input wire logic [7:0] sfr_wdata, // write data
  output logic [7:0] sfr_rdata, // read data, registered
  input wire logic ext_irq_pin_zero, // external pin 0, async
  input wire logic ext_irq_pin_one, // external pin 1, async
  input wire logic ovp_event, // over-voltage detected
  input wire logic ocp_event, // over-current detected
  input wire logic conv_done_event, // conversion complete
  input wire logic tb0_event, // time base 0 tick
  input wire logic tb1_event, // time base 1 tick
  input wire logic t0_cmpa_event, // timer 0 compare a match
  input wire logic t0_cmpp_event, // timer 0 compare p match
  input wire logic t1_cmpa_event, // timer 1 compare a match
  input wire logic t1_cmpp_event, // timer 1 compare p match
  input wire logic eeprom_event, // data eeprom done
  input wire logic low_voltage_event, // low voltage detected
  output logic irq_req, // service request to core
  output logic [ifb_pkg::VEC_W-1:0] irq_vec, // vector being offered
  input wire logic irq_ack // core takes irq_vec, one cycle
);
  typedef struct packed {
    logic [7:0] ext_edge_select;
    logic [7:0] primary_irq_ctrl_zero;
    logic [7:0] primary_irq_ctrl_one;
    logic [7:0] primary_irq_ctrl_two;
    logic [7:0] group_irq_ctrl_zero;
    logic [7:0] group_irq_ctrl_one;
    logic [7:0] group_irq_ctrl_two;
    logic req;
    logic [VEC_W-1:0] vec;
    logic [7:0] rdata;
  } ifb_bank_state_t;

  ifb_bank_state_t s_reg;
  ifb_bank_state_t s_next;
  logic ext_pin0_edge;
  logic ext_pin1_edge;
  logic [NUM_VEC-1:0] pend_req;
  logic pend_any;
  logic [VEC_W-1:0] pend_idx;

  // masked byte for one register select
  function automatic logic [7:0] sel_mask(input logic [SEL_W-1:0] sel);
    case (sel)
      SEL_EXT_EDGE_SELECT: return MASK_EXT_EDGE_SELECT;
      SEL_PRIMARY_ZERO: return MASK_PRIMARY_ZERO;
      SEL_PRIMARY_ONE: return MASK_PRIMARY_ONE;
      SEL_PRIMARY_TWO: return MASK_PRIMARY_TWO;
      SEL_GROUP_ZERO: return MASK_GROUP;
      SEL_GROUP_ONE: return MASK_GROUP;
      SEL_GROUP_TWO: return MASK_GROUP;
      default: return 8'h00;
    endcase
  endfunction : sel_mask

  // group pending: any member holding both flag and enable
  function automatic logic member_live(input logic [7:0] g);
    return (g[B_MEMP_FLAG] & g[B_MEMP_EN]) | (g[B_MEMA_FLAG] & g[B_MEMA_EN]);
  endfunction : member_live

  // edge detectors on the two external pins
  ifb_edge_detect u_edge0 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_async(ext_irq_pin_zero),
    .edge_sel(s_reg.ext_edge_select[EDGE0_LSB+:2]),
    .edge_pulse(ext_pin0_edge)
  );

  ifb_edge_detect u_edge1 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_async(ext_irq_pin_one),
    .edge_sel(s_reg.ext_edge_select[EDGE1_LSB+:2]),
    .edge_pulse(ext_pin1_edge)
  );

  // enabled pending requests in priority order
  always_comb
  begin
    pend_req = '0;
    pend_req[VEC_EXT0] = s_reg.primary_irq_ctrl_zero[B_EXT0_FLAG] & s_reg.primary_irq_ctrl_zero[B_EXT0_EN];
    pend_req[VEC_OCP] = s_reg.primary_irq_ctrl_zero[B_OCP_FLAG] & s_reg.primary_irq_ctrl_zero[B_OCP_EN];
    pend_req[VEC_OVP] = s_reg.primary_irq_ctrl_zero[B_OVP_FLAG] & s_reg.primary_irq_ctrl_zero[B_OVP_EN];
    pend_req[VEC_ADC] = s_reg.primary_irq_ctrl_one[B_ADC_FLAG] & s_reg.primary_irq_ctrl_one[B_ADC_EN];
    pend_req[VEC_GRP0] = s_reg.primary_irq_ctrl_one[B_GRP0_FLAG] & s_reg.primary_irq_ctrl_one[B_GRP0_EN]
      & member_live(s_reg.group_irq_ctrl_zero);
    pend_req[VEC_GRP1] = s_reg.primary_irq_ctrl_one[B_GRP1_FLAG] & s_reg.primary_irq_ctrl_one[B_GRP1_EN]
      & member_live(s_reg.group_irq_ctrl_one);
    pend_req[VEC_GRP2] = s_reg.primary_irq_ctrl_one[B_GRP2_FLAG] & s_reg.primary_irq_ctrl_one[B_GRP2_EN]
      & member_live(s_reg.group_irq_ctrl_two);
    pend_req[VEC_TB0] = s_reg.primary_irq_ctrl_two[B_TB0_FLAG] & s_reg.primary_irq_ctrl_two[B_TB0_EN];
    pend_req[VEC_TB1] = s_reg.primary_irq_ctrl_two[B_TB1_FLAG] & s_reg.primary_irq_ctrl_two[B_TB1_EN];
    pend_req[VEC_EXT1] = s_reg.primary_irq_ctrl_two[B_EXT1_FLAG] & s_reg.primary_irq_ctrl_two[B_EXT1_EN];
  end

  // fixed priority pick
  ifb_priority #(
    .N(NUM_VEC)
  ) u_prio (
    .req(pend_req),
    .any_req(pend_any),
    .win_idx(pend_idx)
  );

  // next state: write, service clear, then hardware sets (set wins)
  always_comb
  begin
    logic [7:0] wval;
    logic [7:0] g0_old;
    logic [7:0] g1_old;
    logic [7:0] g2_old;
    logic take;
    s_next = s_reg;
    wval = sfr_wdata & sel_mask(sfr_sel);
    g0_old = s_reg.group_irq_ctrl_zero;
    g1_old = s_reg.group_irq_ctrl_one;
    g2_old = s_reg.group_irq_ctrl_two;
    take = irq_ack & s_reg.req;
    // software writes of flags and enables
    if (sfr_wr)
    begin
      case (sfr_sel)
        SEL_EXT_EDGE_SELECT: s_next.ext_edge_select = wval;
        SEL_PRIMARY_ZERO: s_next.primary_irq_ctrl_zero = wval;
        SEL_PRIMARY_ONE: s_next.primary_irq_ctrl_one = wval;
        SEL_PRIMARY_TWO: s_next.primary_irq_ctrl_two = wval;
        SEL_GROUP_ZERO: s_next.group_irq_ctrl_zero = wval;
        SEL_GROUP_ONE: s_next.group_irq_ctrl_one = wval;
        SEL_GROUP_TWO: s_next.group_irq_ctrl_two = wval;
        default: s_next.rdata = s_next.rdata;
      endcase
    end
    // service taken: drop global enable and the serviced primary flag
    if (take)
    begin
      s_next.primary_irq_ctrl_zero[B_GLOBAL_EN] = 1'b0;
      case (s_reg.vec)
        VEC_EXT0: s_next.primary_irq_ctrl_zero[B_EXT0_FLAG] = 1'b0;
        VEC_OCP: s_next.primary_irq_ctrl_zero[B_OCP_FLAG] = 1'b0;
        VEC_OVP: s_next.primary_irq_ctrl_zero[B_OVP_FLAG] = 1'b0;
        VEC_ADC: s_next.primary_irq_ctrl_one[B_ADC_FLAG] = 1'b0;
        VEC_GRP0: s_next.primary_irq_ctrl_one[B_GRP0_FLAG] = 1'b0;
        VEC_GRP1: s_next.primary_irq_ctrl_one[B_GRP1_FLAG] = 1'b0;
        VEC_GRP2: s_next.primary_irq_ctrl_one[B_GRP2_FLAG] = 1'b0;
        VEC_TB0: s_next.primary_irq_ctrl_two[B_TB0_FLAG] = 1'b0;
        VEC_TB1: s_next.primary_irq_ctrl_two[B_TB1_FLAG] = 1'b0;
        VEC_EXT1: s_next.primary_irq_ctrl_two[B_EXT1_FLAG] = 1'b0;
        default: s_next.req = 1'b0;
      endcase
    end
    // hardware event sets, applied last so a same-cycle clear loses
    if (ext_pin0_edge)
      s_next.primary_irq_ctrl_zero[B_EXT0_FLAG] = 1'b1;
    if (ocp_event)
      s_next.primary_irq_ctrl_zero[B_OCP_FLAG] = 1'b1;
    if (ovp_event)
      s_next.primary_irq_ctrl_zero[B_OVP_FLAG] = 1'b1;
    if (conv_done_event)
      s_next.primary_irq_ctrl_one[B_ADC_FLAG] = 1'b1;
    if (ext_pin1_edge)
      s_next.primary_irq_ctrl_two[B_EXT1_FLAG] = 1'b1;
    if (tb1_event)
      s_next.primary_irq_ctrl_two[B_TB1_FLAG] = 1'b1;
    if (tb0_event)
      s_next.primary_irq_ctrl_two[B_TB0_FLAG] = 1'b1;
    if (t0_cmpa_event)
      s_next.group_irq_ctrl_zero[B_MEMA_FLAG] = 1'b1;
    if (t0_cmpp_event)
      s_next.group_irq_ctrl_zero[B_MEMP_FLAG] = 1'b1;
    if (t1_cmpa_event)
      s_next.group_irq_ctrl_one[B_MEMA_FLAG] = 1'b1;
    if (t1_cmpp_event)
      s_next.group_irq_ctrl_one[B_MEMP_FLAG] = 1'b1;
    if (eeprom_event)
      s_next.group_irq_ctrl_two[B_MEMA_FLAG] = 1'b1;
    if (low_voltage_event)
      s_next.group_irq_ctrl_two[B_MEMP_FLAG] = 1'b1;
    // a member flag going from clear to set raises its group flag
    if (|(s_next.group_irq_ctrl_zero[B_MEMA_FLAG:B_MEMP_FLAG] & ~g0_old[B_MEMA_FLAG:B_MEMP_FLAG]))
      s_next.primary_irq_ctrl_one[B_GRP0_FLAG] = 1'b1;
    if (|(s_next.group_irq_ctrl_one[B_MEMA_FLAG:B_MEMP_FLAG] & ~g1_old[B_MEMA_FLAG:B_MEMP_FLAG]))
      s_next.primary_irq_ctrl_one[B_GRP1_FLAG] = 1'b1;
    if (|(s_next.group_irq_ctrl_two[B_MEMA_FLAG:B_MEMP_FLAG] & ~g2_old[B_MEMA_FLAG:B_MEMP_FLAG]))
      s_next.primary_irq_ctrl_one[B_GRP2_FLAG] = 1'b1;
    // offer the winner only while the global enable is set and not just taken
    s_next.req = pend_any & s_next.primary_irq_ctrl_zero[B_GLOBAL_EN] & ~take;
    s_next.vec = pend_idx;
    // registered read path; unmapped selects read zero
    case (sfr_sel)
      SEL_EXT_EDGE_SELECT: s_next.rdata = s_reg.ext_edge_select & MASK_EXT_EDGE_SELECT;
      SEL_PRIMARY_ZERO: s_next.rdata = s_reg.primary_irq_ctrl_zero & MASK_PRIMARY_ZERO;
      SEL_PRIMARY_ONE: s_next.rdata = s_reg.primary_irq_ctrl_one & MASK_PRIMARY_ONE;
      SEL_PRIMARY_TWO: s_next.rdata = s_reg.primary_irq_ctrl_two & MASK_PRIMARY_TWO;
      SEL_GROUP_ZERO: s_next.rdata = s_reg.group_irq_ctrl_zero & MASK_GROUP;
      SEL_GROUP_ONE: s_next.rdata = s_reg.group_irq_ctrl_one & MASK_GROUP;
      SEL_GROUP_TWO: s_next.rdata = s_reg.group_irq_ctrl_two & MASK_GROUP;
      default: s_next.rdata = 8'h00;
    endcase
  end

  // state register, all cleared at reset
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_reg.ext_edge_select <= REG_RESET;
      s_reg.primary_irq_ctrl_zero <= REG_RESET;
      s_reg.primary_irq_ctrl_one <= REG_RESET;
      s_reg.primary_irq_ctrl_two <= REG_RESET;
      s_reg.group_irq_ctrl_zero <= REG_RESET;
      s_reg.group_irq_ctrl_one <= REG_RESET;
      s_reg.group_irq_ctrl_two <= REG_RESET;
      s_reg.req <= 1'b0;
      s_reg.vec <= '0;
      s_reg.rdata <= REG_RESET;
    end
    else
      s_reg <= s_next;
  end

  // outputs straight from flip-flops
  assign sfr_rdata = s_reg.rdata;
  assign irq_req = s_reg.req;
  assign irq_vec = s_reg.vec;
endmodule : ifb_bank
`default_nettype wire

// File: logic/ifb_pkg.sv
// ifb_pkg: register indices, bit positions, masks, reset values and
// service vector numbers for the interrupt flag and enable bank.
// assumes: shared by ifb_bank and its helpers, all on clk_sys.
`default_nettype none
package ifb_pkg;
  // special-function register selects
  localparam int unsigned SEL_W = 3;
  localparam logic [2:0] SEL_EXT_EDGE_SELECT = 3'h0;
  localparam logic [2:0] SEL_PRIMARY_ZERO = 3'h1;
  localparam logic [2:0] SEL_PRIMARY_ONE = 3'h2;
  localparam logic [2:0] SEL_PRIMARY_TWO = 3'h3;
  localparam logic [2:0] SEL_GROUP_ZERO = 3'h4;
  localparam logic [2:0] SEL_GROUP_ONE = 3'h5;
  localparam logic [2:0] SEL_GROUP_TWO = 3'h6;
  // writable / readable bits of each register
  localparam logic [7:0] MASK_EXT_EDGE_SELECT = 8'h0F;
  localparam logic [7:0] MASK_PRIMARY_ZERO = 8'h7F;
  localparam logic [7:0] MASK_PRIMARY_ONE = 8'hFF;
  localparam logic [7:0] MASK_PRIMARY_TWO = 8'h77;
  localparam logic [7:0] MASK_GROUP = 8'h33;
  localparam logic [7:0] REG_RESET = 8'h00;
  // edge select field positions and codes
  localparam int unsigned EDGE0_LSB = 0;
  localparam int unsigned EDGE1_LSB = 2;
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // primary register zero
  localparam int unsigned B_GLOBAL_EN = 0;
  localparam int unsigned B_OVP_EN = 1;
  localparam int unsigned B_OCP_EN = 2;
  localparam int unsigned B_EXT0_EN = 3;
  localparam int unsigned B_OVP_FLAG = 4;
  localparam int unsigned B_OCP_FLAG = 5;
  localparam int unsigned B_EXT0_FLAG = 6;
  // primary register one
  localparam int unsigned B_GRP0_EN = 0;
  localparam int unsigned B_GRP1_EN = 1;
  localparam int unsigned B_GRP2_EN = 2;
  localparam int unsigned B_ADC_EN = 3;
  localparam int unsigned B_GRP0_FLAG = 4;
  localparam int unsigned B_GRP1_FLAG = 5;
  localparam int unsigned B_GRP2_FLAG = 6;
  localparam int unsigned B_ADC_FLAG = 7;
  // primary register two
  localparam int unsigned B_TB0_EN = 0;
  localparam int unsigned B_TB1_EN = 1;
  localparam int unsigned B_EXT1_EN = 2;
  localparam int unsigned B_TB0_FLAG = 4;
  localparam int unsigned B_TB1_FLAG = 5;
  localparam int unsigned B_EXT1_FLAG = 6;
  // group registers: member p at bit 0/4, member a at bit 1/5
  localparam int unsigned B_MEMP_EN = 0;
  localparam int unsigned B_MEMA_EN = 1;
  localparam int unsigned B_MEMP_FLAG = 4;
  localparam int unsigned B_MEMA_FLAG = 5;
  // service vectors, lower number wins
  localparam int unsigned NUM_VEC = 10;
  localparam int unsigned VEC_W = 4;
  localparam logic [3:0] VEC_EXT0 = 4'h0;
  localparam logic [3:0] VEC_OCP = 4'h1;
  localparam logic [3:0] VEC_OVP = 4'h2;
  localparam logic [3:0] VEC_ADC = 4'h3;
  localparam logic [3:0] VEC_GRP0 = 4'h4;
  localparam logic [3:0] VEC_GRP1 = 4'h5;
  localparam logic [3:0] VEC_GRP2 = 4'h6;
  localparam logic [3:0] VEC_TB0 = 4'h7;
  localparam logic [3:0] VEC_TB1 = 4'h8;
  localparam logic [3:0] VEC_EXT1 = 4'h9;
endpackage : ifb_pkg
`default_nettype wire

// File: logic/ifb_edge_detect.sv
// ifb_edge_detect: synchronises one external interrupt pin and reports
// the edge kind chosen by a two-bit select as a one-cycle pulse.
// assumes: pin is asynchronous to clk_sys; select comes from clk_sys logic.
`default_nettype none
module ifb_edge_detect
  import ifb_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic pin_async, // raw pin level
  input wire logic [1:0] edge_sel, // edge select code
  output logic edge_pulse // one-cycle edge event
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
  } ifb_edge_state_t;

  ifb_edge_state_t s_reg;
  ifb_edge_state_t s_next;

  // two-stage synchroniser then one history stage
  always_comb
  begin
    s_next = s_reg;
    s_next.sync1 = pin_async;
    s_next.sync2 = s_reg.sync1;
    s_next.prev = s_reg.sync2;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  // decode of the select code
  always_comb
  begin
    case (edge_sel)
      EDGE_OFF: edge_pulse = 1'b0;
      EDGE_RISE: edge_pulse = s_reg.sync2 & ~s_reg.prev;
      EDGE_FALL: edge_pulse = ~s_reg.sync2 & s_reg.prev;
      EDGE_BOTH: edge_pulse = s_reg.sync2 ^ s_reg.prev;
      default: edge_pulse = 1'b0;
    endcase
  end
endmodule : ifb_edge_detect
`default_nettype wire

// File: logic/ifb_priority.sv
// ifb_priority: fixed-priority pick among enabled requests, index 0 first.
// assumes: purely combinational; the caller registers the result.
`default_nettype none
module ifb_priority
  import ifb_pkg::*;
#(
  parameter int unsigned N = NUM_VEC
)
(
  input wire logic [N-1:0] req, // enabled pending requests
  output logic any_req, // at least one request
  output logic [VEC_W-1:0] win_idx // winning index
);
  // lowest set index of a request vector
  function automatic logic [VEC_W-1:0] first_set(input logic [N-1:0] v);
    logic [VEC_W-1:0] idx;
    idx = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (v[i])
        idx = VEC_W'(i);
    end
    return idx;
  endfunction : first_set

  // winner and presence
  assign any_req = |req;
  assign win_idx = first_set(req);
endmodule : ifb_priority
`default_nettype wire

// File: test/ifb_core_model.sv
// ifb_core_model: program sequencer stand-in that takes offered vectors.
// assumes: irq_req and irq_vec change only on rising clk_sys edges.
`default_nettype none
module ifb_core_model
  import ifb_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic rst_n, // reset, low
  input wire logic irq_req, // request
  input wire logic [VEC_W-1:0] irq_vec, // vector
  input wire logic take_en, // core accepts
  input wire logic [3:0] ack_delay, // wait cycles
  output logic irq_ack, // take pulse
  output logic [VEC_W-1:0] last_vec, // last taken
  output int unsigned num_taken // taken count
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned wait_cnt;
  // no take pulse before the first reset edge lands
  initial irq_ack = 1'b0;
  // take after ack_delay request cycles, then the main flow resumes
  always @(negedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_ack <= 1'b0;
      last_vec <= '0;
      num_taken <= 0;
      wait_cnt <= 0;
    end
    else if (irq_ack || !irq_req || !take_en)
    begin
      irq_ack <= 1'b0;
      wait_cnt <= 0;
    end
    else if (wait_cnt >= ack_delay)
    begin
      irq_ack <= 1'b1;
      last_vec <= irq_vec;
      num_taken <= num_taken + 1;
    end
    else
      wait_cnt <= wait_cnt + 1;
  end
endmodule : ifb_core_model
`default_nettype wire

// File: test/ifb_bank_monitor.sv
// ifb_bank_monitor: port checks of the interrupt flag and enable bank.
// assumes: bound to ifb_bank, one clk_sys domain.
`default_nettype none
module ifb_bank_monitor
  import ifb_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic rst_n, // reset, low
  input wire logic [SEL_W-1:0] sfr_sel, // select
  input wire logic sfr_wr, // write strobe
  input wire logic [7:0] sfr_wdata, // write data
  input wire logic [7:0] sfr_rdata, // read data
  input wire logic ovp_event, // voltage event
  input wire logic irq_req, // request
  input wire logic [VEC_W-1:0] irq_vec, // vector
  input wire logic irq_ack // take pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] LIVE [8] = '{8'h0F, 8'h7F, 8'hFF, 8'h77, 8'h33, 8'h33, 8'h33, 8'h00};
  logic wr_ctl0;
  // software write to primary zero
  assign wr_ctl0 = sfr_wr && sfr_sel == SEL_PRIMARY_ZERO;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  reset_clear_a:
    assert property ($rose(rst_n) |-> sfr_rdata == 8'h00 && !irq_req)
    else $error("not clear after reset");
  unimpl_zero_a:
    assert property ((sfr_rdata & ~LIVE[$past(sfr_sel)]) == 8'h00)
    else $error("unimplemented bit read as one");
  edge_sel_rw_a:
    assert property (sfr_wr && sfr_sel == SEL_EXT_EDGE_SELECT ##1 sfr_sel == SEL_EXT_EDGE_SELECT
      |=> sfr_rdata == ($past(sfr_wdata, 2) & 8'h0F))
    else $error("edge select readback wrong");
  ovp_flag_a:
    assert property (ovp_event ##1 sfr_sel == SEL_PRIMARY_ZERO |=> sfr_rdata[B_OVP_FLAG])
    else $error("over-voltage flag not set");
  take_drop_a:
    assert property (irq_req && irq_ack |=> !irq_req)
    else $error("request held after take");
  no_nesting_a:
    assert property (irq_req && irq_ack && !wr_ctl0 ##1 !wr_ctl0 [*3] |=> !irq_req)
    else $error("nested request offered");
  global_off_a:
    assert property (wr_ctl0 && !sfr_wdata[B_GLOBAL_EN] ##1 !wr_ctl0 |=> !irq_req)
    else $error("request with global enable off");
  vec_range_a:
    assert property (irq_req |-> irq_vec < NUM_VEC)
    else $error("vector out of range");
  // main scenarios reached
  cover property (irq_req && irq_ack);
  cover property ($rose(irq_req) && irq_vec == VEC_GRP0);
  cover property (sfr_wr && sfr_sel == 3'h7);
endmodule : ifb_bank_monitor
`default_nettype wire

// File: test/ifb_bank_tb.sv
// ifb_bank_tb: register, event, edge and service tests of ifb_bank.
// assumes: ifb_core_model takes vectors; the monitor is bound below.
`default_nettype none
module ifb_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ifb_pkg::*;
  logic clk_sys = 1'b0, rst_n = 1'b0, sfr_wr = 1'b0, pin0 = 1'b0, pin1 = 1'b0, take_en = 1'b0;
  logic [2:0] sfr_sel = 3'h0;
  logic [7:0] sfr_wdata = 8'h00, sfr_rdata;
  logic [10:0] ev = 11'h000;
  logic irq_req, irq_ack;
  logic [3:0] irq_vec, last_vec, ack_delay = 4'h0;
  int unsigned num_taken;
  int mismatches = 0, num_checks = 0;
  logic [7:0] mask [8] = '{8'h0F, 8'h7F, 8'hFF, 8'h77, 8'h33, 8'h33, 8'h33, 8'h00};
  // 50 MHz clock
  initial forever #10 clk_sys = ~clk_sys;
  ifb_bank uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .sfr_sel(sfr_sel), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .ext_irq_pin_zero(pin0), .ext_irq_pin_one(pin1), .ovp_event(ev[0]),
    .ocp_event(ev[1]), .conv_done_event(ev[2]), .tb0_event(ev[3]), .tb1_event(ev[4]), .t0_cmpa_event(ev[5]),
    .t0_cmpp_event(ev[6]), .t1_cmpa_event(ev[7]), .t1_cmpp_event(ev[8]), .eeprom_event(ev[9]),
    .low_voltage_event(ev[10]), .irq_req(irq_req), .irq_vec(irq_vec), .irq_ack(irq_ack)
  );
  ifb_core_model core (
    .clk_sys(clk_sys), .rst_n(rst_n), .irq_req(irq_req), .irq_vec(irq_vec), .take_en(take_en),
    .ack_delay(ack_delay), .irq_ack(irq_ack), .last_vec(last_vec), .num_taken(num_taken)
  );
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    num_checks++;
    if (got !== want)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  endtask : chk
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    @(negedge clk_sys);
    sfr_sel = s;
    sfr_wr = 1'b1;
    sfr_wdata = d;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
  endtask : wr
  task automatic rck(input logic [2:0] s, input logic [7:0] want);
    @(negedge clk_sys);
    sfr_sel = s;
    @(negedge clk_sys);
    chk(sfr_rdata, want);
  endtask : rck
  task automatic pulse(input int i);
    @(negedge clk_sys);
    ev[i] = 1'b1;
    @(negedge clk_sys);
    ev[i] = 1'b0;
  endtask : pulse
  task automatic test_done();
    if (mismatches == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done
  // watchdog against a hung run
  initial
  begin
    #50us;
    mismatches++;
    test_done();
  end
  // main sequence
  initial
  begin
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    for (int s = 0; s < 8; s++) rck(3'(s), 8'h00);
    // all-ones write keeps only implemented bits, unmapped select included
    for (int s = 0; s < 8; s++) wr(3'(s), 8'hFF);
    for (int s = 0; s < 8; s++) rck(3'(s), mask[s]);
    for (int s = 0; s < 7; s++) wr(3'(s), 8'h00);
    // each edge code on both pins, rise then fall
    for (int c = 0; c < 4; c++)
    begin
      wr(SEL_EXT_EDGE_SELECT, 8'(c * 5));
      {pin0, pin1} = 2'b11;
      repeat (5) @(negedge clk_sys);
      rck(SEL_PRIMARY_ZERO, {1'b0, c[0], 6'h00});
      rck(SEL_PRIMARY_TWO, {1'b0, c[0], 6'h00});
      wr(SEL_PRIMARY_TWO, 8'h00);
      wr(SEL_PRIMARY_ZERO, 8'h00);
      {pin0, pin1} = 2'b00;
      repeat (5) @(negedge clk_sys);
      rck(SEL_PRIMARY_ZERO, {1'b0, c[1], 6'h00});
      rck(SEL_PRIMARY_TWO, {1'b0, c[1], 6'h00});
      wr(SEL_PRIMARY_TWO, 8'h00);
      wr(SEL_PRIMARY_ZERO, 8'h00);
    end
    // every event input except the pins sets its flag while all enables are off
    for (int i = 0; i < 11; i++) pulse(i);
    repeat (3) @(negedge clk_sys);
    chk({7'h00, irq_req}, 8'h00);
    rck(SEL_PRIMARY_ZERO, 8'h30);
    rck(SEL_PRIMARY_ONE, 8'hF0);
    rck(SEL_PRIMARY_TWO, 8'h30);
    for (int s = 4; s < 7; s++) rck(3'(s), 8'h30);
    wr(SEL_PRIMARY_ONE, 8'h00);
    rck(SEL_GROUP_ONE, 8'h30);
    for (int s = 4; s < 7; s++) wr(3'(s), 8'h00);
    // two pending: higher priority taken first, global enable cleared
    take_en = 1'b1;
    wr(SEL_PRIMARY_ZERO, 8'h37);
    repeat (10) @(negedge clk_sys);
    chk({4'h0, last_vec}, {4'h0, VEC_OCP});
    rck(SEL_PRIMARY_ZERO, 8'h16);
    // slow core takes the remaining one after re-enable
    ack_delay = 4'h5;
    wr(SEL_PRIMARY_ZERO, 8'h17);
    repeat (12) @(negedge clk_sys);
    chk({4'h0, last_vec}, {4'h0, VEC_OVP});
    rck(SEL_PRIMARY_ZERO, 8'h06);
    // group offered through an enabled member; member flag survives service
    wr(SEL_PRIMARY_ZERO, 8'h00);
    wr(SEL_PRIMARY_ONE, 8'h01);
    wr(SEL_GROUP_ZERO, 8'h02);
    pulse(5);
    repeat (3) @(negedge clk_sys);
    chk({7'h00, irq_req}, 8'h00);
    wr(SEL_PRIMARY_ZERO, 8'h01);
    repeat (8) @(negedge clk_sys);
    chk({4'h0, last_vec}, {4'h0, VEC_GRP0});
    rck(SEL_GROUP_ZERO, 8'h22);
    rck(SEL_PRIMARY_ONE, 8'h01);
    chk(8'(num_taken), 8'h03);
    test_done();
  end
endmodule : ifb_bank_tb
bind ifb_bank ifb_bank_monitor mon (
  .clk_sys(clk_sys), .rst_n(rst_n), .sfr_sel(sfr_sel), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
  .sfr_rdata(sfr_rdata), .ovp_event(ovp_event), .irq_req(irq_req), .irq_vec(irq_vec), .irq_ack(irq_ack)
);
`default_nettype wire
